// ### core/dfm_ecc_check.sv
// Purpose: secded check of one protected word
// Assumes: word layout {overall parity, hamming word[20:1]} with bit 0 unused
// Notes:   combinational; corrected data and single/double error strobes
`timescale 1ns/1ps
module dfm_ecc_check #(
  parameter int DATA_W = dfm_pkg::ECC_DATA_W
) (
  input  wire logic [dfm_pkg::ECC_CODE_W-1:0] code_in,
  input  wire logic                           code_valid,
  output logic      [DATA_W-1:0]              data_out,
  output logic                                single_err,
  output logic                                double_err
);

  // ----------------------------------------------------------------
  // syndrome and correction
  // ----------------------------------------------------------------
  logic [dfm_pkg::ECC_CODE_W-1:0] fixed;
  logic [4:0]                     syn;
  logic                           par;
  int                             k;

  always_comb begin
    syn   = 5'h00;
    par   = ^code_in;
    fixed = code_in;
    for (int i = 1; i < dfm_pkg::ECC_CODE_W - 1; i++) begin
      if (code_in[i]) begin
        syn = syn ^ i[4:0];
      end
    end
    if (syn != 5'h00 && par) begin
      fixed[syn] = ~code_in[syn];
    end
    data_out = '0;
    k        = 0;
    for (int i = 1; i < dfm_pkg::ECC_CODE_W - 1; i++) begin
      if ((i & (i - 1)) != 0) begin
        if (k < DATA_W) begin
          data_out[k] = fixed[i];
        end
        k = k + 1;
      end
    end
    single_err = code_valid && par;                    // RL14
    double_err = code_valid && !par && syn != 5'h00;   // RL14
  end

endmodule : dfm_ecc_check

// ### core/dfm_monitor.sv
// Purpose: diagnostic flag collection, output shutdown and interrupt pin
// Assumes: analog comparators and detectors deliver synchronous levels
// Notes:   flags leave as a vector; positions named in dfm_pkg
`timescale 1ns/1ps
//
// Contract
// RL1 - offset beyond limit sets temporary buffer flag and shuts outputs off.
// RL2 - buffer fault after eight checks latches shutdown and static buffer flag.
// RL3 - buffer latch released by power-on reset or host clear.
// RL4 - overcurrent sets temporary flag; after debounce all outputs tri-state.
// RL5 - after retry delay outputs re-enable and overcurrent is checked again.
// RL6 - overload after eight retries latches shutdown and static overload flag.
// RL7 - overload latch released by power-on reset or host clear.
// RL8 - receiver coil shorts or opens set a temporary flag.
// RL9 - transmitter coil fault sets a temporary flag.
// RL10 - over-temperature or sensor failure sets a temporary flag.
// RL11 - internal supply and digital errors latch as static flags.
// RL12 - gain at either programmed limit sets a temporary flag.
// RL13 - self-test checked at start-up only, latched static on failure.
// RL14 - every stored word is secded protected.
// RL15 - any ecc error raises an alarm flag.
// RL16 - transmitter frequency measured and held readable.
// RL17 - measurement outside programmed bounds raises an alarm flag.
// RL18 - static flags hold until power-on reset unless host clear exists.
// RL19 - temporary flags clear once their cause is gone; buffer and overload flags hold through each off period until the recheck.
// RL20 - each diagnostic individually enabled onto the interrupt pin.
// RL21 - events may also drive the analog outputs into diagnostic state.
// RL22 - retry counts restart on a clean check, reset or static clear.
// RL23 - latched shutdown keeps outputs off with no further retries.
module dfm_monitor #(
  parameter int OC_ASSERT_CYC   = dfm_pkg::OC_ASSERT_CYC,
  parameter int OC_DEASSERT_CYC = dfm_pkg::OC_DEASSERT_CYC,
  parameter int BUF_CHECK_CYC   = dfm_pkg::BUF_CHECK_CYC,
  parameter int FREQ_W          = dfm_pkg::FREQ_W
) (
  input  wire logic                               clk_sys,
  input  wire logic                               reset,
  input  wire logic                               clk_en,
  input  wire logic                               startup_window,
  input  wire logic                               output_offset_alarm,
  input  wire logic                               output_overcurrent,
  input  wire logic                               rx_coil_fault,
  input  wire logic                               tx_coil_fault,
  input  wire logic                               temp_fault,
  input  wire logic                               supply_fault,
  input  wire logic [7:0]                         gain_value,
  input  wire logic [7:0]                         gain_limit_low,
  input  wire logic [7:0]                         gain_limit_high,
  input  wire logic                               digital_fault,
  input  wire logic                               self_test_fail,
  input  wire logic [dfm_pkg::ECC_CODE_W-1:0]     ecc_word,
  input  wire logic                               ecc_word_valid,
  input  wire logic                               tx_osc_tick,
  input  wire logic                               meas_gate,
  input  wire logic [FREQ_W-1:0]                  freq_limit_low,
  input  wire logic [FREQ_W-1:0]                  freq_limit_high,
  input  wire logic [dfm_pkg::NFLAG-1:0]          irq_enable,
  input  wire logic                               diag_on_outputs,
  input  wire logic                               clear_buf_static,
  input  wire logic                               clear_ol_static,
  output logic      [dfm_pkg::NFLAG-1:0]          diag_flags,
  output logic      [FREQ_W-1:0]                  freq_measure,
  output logic      [dfm_pkg::ECC_DATA_W-1:0]     ecc_data,
  output logic                                    analog_out_enable,
  output logic                                    analog_diag_state,
  output logic                                    addr_select_irq_pin_o,
  output logic                                    addr_select_irq_pin_oe_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                               rx;
    logic                               tx;
    logic                               temp;
    logic                               supply;
    logic                               gain;
    logic                               digital;
    logic                               self_test;
    logic                               sed;
    logic                               ded;
    logic                               freq;
    logic [FREQ_W-1:0]                  freq_cnt;
    logic [FREQ_W-1:0]                  freq_val;
    logic                               freq_done;
    logic [dfm_pkg::ECC_DATA_W-1:0]     ecc_d;
    logic                               irq;
  } dfm_state_t;

  dfm_state_t s_reg;
  dfm_state_t s_next;

  logic buf_temp;
  logic buf_stat;
  logic buf_off;
  logic ol_temp;
  logic ol_stat;
  logic ol_off;
  logic [dfm_pkg::ECC_DATA_W-1:0] ecc_fixed;
  logic ecc_single;
  logic ecc_double;
  logic [dfm_pkg::NFLAG-1:0] flags;

  function automatic logic outside(input logic [FREQ_W-1:0] v,
                                   input logic [FREQ_W-1:0] lo,
                                   input logic [FREQ_W-1:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction : outside

  // ----------------------------------------------------------------
  // output fault sequencers and ecc check
  // ----------------------------------------------------------------
  // buffer offset fault shuts off at once, hence a one-cycle debounce
  dfm_retry_ctrl #(
    .ASSERT_CYC (1),
    .CHECK_CYC  (BUF_CHECK_CYC)
  ) u_buf (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .clk_en       (clk_en),
    .fault_in     (output_offset_alarm),
    .static_clear (clear_buf_static),
    .temp_flag    (buf_temp),
    .static_flag  (buf_stat),
    .outputs_off  (buf_off)
  );

  dfm_retry_ctrl #(
    .ASSERT_CYC (OC_ASSERT_CYC),
    .CHECK_CYC  (OC_DEASSERT_CYC)
  ) u_ol (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .clk_en       (clk_en),
    .fault_in     (output_overcurrent),
    .static_clear (clear_ol_static),
    .temp_flag    (ol_temp),
    .static_flag  (ol_stat),
    .outputs_off  (ol_off)
  );

  dfm_ecc_check #(
    .DATA_W (dfm_pkg::ECC_DATA_W)
  ) u_ecc (
    .code_in    (ecc_word),
    .code_valid (ecc_word_valid),
    .data_out   (ecc_fixed),
    .single_err (ecc_single),
    .double_err (ecc_double)
  );

  // ----------------------------------------------------------------
  // flag logic
  // ----------------------------------------------------------------
  always_comb begin
    s_next           = s_reg;
    s_next.rx        = rx_coil_fault; // RL8
    s_next.tx        = tx_coil_fault; // RL9
    s_next.temp      = temp_fault; // RL10
    s_next.supply    = s_reg.supply | supply_fault; // RL11
    s_next.digital   = s_reg.digital | digital_fault; // RL11
    s_next.gain      = (gain_value <= gain_limit_low) ||
                       (gain_value >= gain_limit_high); // RL12
    if (startup_window) begin
      s_next.self_test = s_reg.self_test | self_test_fail; // RL13
    end
    if (ecc_word_valid) begin
      s_next.sed   = ecc_single; // RL19
      s_next.ecc_d = ecc_fixed; // RL14
    end
    s_next.ded       = s_reg.ded | ecc_double; // RL15 RL18
    // counting ticks in a gate window trades latency for a simple counter
    if (meas_gate) begin
      s_next.freq_done = 1'b0;
      if (tx_osc_tick && s_reg.freq_cnt != {FREQ_W{1'b1}}) begin
        s_next.freq_cnt = s_reg.freq_cnt + 1'b1;
      end
    end else if (!s_reg.freq_done) begin
      s_next.freq_val  = s_reg.freq_cnt; // RL16
      s_next.freq_cnt  = '0;
      s_next.freq_done = 1'b1;
    end
    s_next.freq      = outside(s_reg.freq_val, freq_limit_low,
                               freq_limit_high); // RL17
    s_next.irq       = |(flags & irq_enable); // RL20
  end

  always_comb begin
    flags                       = '0;
    flags[dfm_pkg::F_BUF_TEMP]  = buf_temp; // RL1
    flags[dfm_pkg::F_BUF_STAT]  = buf_stat; // RL2
    flags[dfm_pkg::F_OL_TEMP]   = ol_temp; // RL4
    flags[dfm_pkg::F_OL_STAT]   = ol_stat; // RL6
    flags[dfm_pkg::F_RX_COIL]   = s_reg.rx;
    flags[dfm_pkg::F_TX_COIL]   = s_reg.tx;
    flags[dfm_pkg::F_TEMP]      = s_reg.temp;
    flags[dfm_pkg::F_SUPPLY]    = s_reg.supply;
    flags[dfm_pkg::F_GAIN]      = s_reg.gain;
    flags[dfm_pkg::F_DIGITAL]   = s_reg.digital;
    flags[dfm_pkg::F_SELF_TEST] = s_reg.self_test;
    flags[dfm_pkg::F_ECC_SED]   = s_reg.sed;
    flags[dfm_pkg::F_ECC_DED]   = s_reg.ded;
    flags[dfm_pkg::F_FREQ]      = s_reg.freq;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign diag_flags        = flags;
  assign freq_measure      = s_reg.freq_val;
  assign ecc_data          = s_reg.ecc_d;
  // offset fault overrides any diagnostics mode
  assign analog_out_enable = !(buf_off || ol_off || buf_temp); // RL1 RL4 RL23
  assign analog_diag_state = diag_on_outputs && s_reg.irq; // RL21
  // open-drain, low active: drive zero with enable low on an event
  assign addr_select_irq_pin_o    = 1'b0;
  assign addr_select_irq_pin_oe_n = !s_reg.irq; // RL20

endmodule : dfm_monitor

// ### core/dfm_retry_ctrl.sv
// Purpose: shutdown and retry sequencing for one output fault class
// Assumes: fault_in synchronous to clk_sys
// Notes:   while the fault stands, outputs stay off for CHECK_CYC cycles before each recheck
`timescale 1ns/1ps
module dfm_retry_ctrl #(
  parameter int ASSERT_CYC = 1,
  parameter int CHECK_CYC  = 1
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic fault_in,
  input  wire logic static_clear,
  output logic      temp_flag,
  output logic      static_flag,
  output logic      outputs_off
);

  typedef enum logic [1:0] {DFM_RUN, DFM_DEBOUNCE, DFM_OFF, DFM_LATCHED} dfm_rst_t;

  typedef struct packed {
    dfm_rst_t                       st;
    logic [dfm_pkg::TMR_W-1:0]      tmr;
    logic [dfm_pkg::CNT_W-1:0]      cnt;
    logic                           temp;
  } dfm_retry_t;

  dfm_retry_t s_reg;
  dfm_retry_t s_next;

  localparam logic [dfm_pkg::TMR_W-1:0] A_LAST = dfm_pkg::TMR_W'(ASSERT_CYC - 1);
  localparam logic [dfm_pkg::TMR_W-1:0] C_LAST = dfm_pkg::TMR_W'(CHECK_CYC - 1);
  localparam logic [dfm_pkg::CNT_W-1:0] C_MAX  = dfm_pkg::CNT_W'(dfm_pkg::RETRY_LIMIT);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      DFM_RUN: begin
        s_next.temp = fault_in;
        s_next.tmr  = '0;
        if (fault_in) begin
          s_next.st = DFM_DEBOUNCE;
        end else begin
          // a clean recheck after an off period restarts the count
          s_next.cnt = '0; // RL22
        end
      end
      DFM_DEBOUNCE: begin
        s_next.temp = fault_in;
        if (!fault_in) begin
          s_next.st  = DFM_RUN;
          s_next.cnt = '0; // RL22
        end else if (s_reg.tmr >= A_LAST) begin
          s_next.st  = DFM_OFF; // RL4
          s_next.tmr = '0;
          s_next.cnt = s_reg.cnt + 1'b1;
        end else begin
          s_next.tmr = s_reg.tmr + 1'b1;
        end
      end
      DFM_OFF: begin
        if (s_reg.cnt >= C_MAX) begin
          s_next.st = DFM_LATCHED; // RL2 RL6
        end else if (s_reg.tmr >= C_LAST) begin
          s_next.st  = DFM_RUN; // RL5
          s_next.tmr = '0;
        end else begin
          s_next.tmr = s_reg.tmr + 1'b1;
        end
      end
      DFM_LATCHED: begin
        s_next.temp = fault_in;
        if (static_clear) begin
          s_next.st  = DFM_RUN; // RL3 RL7
          s_next.cnt = '0; // RL22
          s_next.tmr = '0;
        end
      end
      default: begin
        s_next.st = DFM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '{st: DFM_RUN, tmr: '0, cnt: '0, temp: 1'b0};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign temp_flag   = s_reg.temp; // RL19
  assign static_flag = (s_reg.st == DFM_LATCHED); // RL18
  assign outputs_off = (s_reg.st == DFM_OFF) || (s_reg.st == DFM_LATCHED); // RL23

endmodule : dfm_retry_ctrl

// ### pkg/dfm_pkg.sv
// Purpose: shared constants for the diagnostic fault monitor
// Assumes: clk_sys at 250 MHz
// Notes:   flag vector positions are fixed here and used by the monitor, its checks and the bench
package dfm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ            = 250;
  localparam int OC_ASSERT_US       = 10;
  localparam int OC_DEASSERT_US     = 1000;
  localparam int BUF_CHECK_US       = 100;
  localparam int OC_ASSERT_CYC      = OC_ASSERT_US * CLK_MHZ;
  localparam int OC_DEASSERT_CYC    = OC_DEASSERT_US * CLK_MHZ;
  localparam int BUF_CHECK_CYC      = BUF_CHECK_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // retry limits
  // ----------------------------------------------------------------
  localparam int RETRY_LIMIT        = 8;
  localparam int CNT_W              = 4;
  localparam int TMR_W              = 20;

  // ----------------------------------------------------------------
  // flag vector positions
  // ----------------------------------------------------------------
  localparam int NFLAG              = 16;
  localparam int F_BUF_TEMP         = 0;
  localparam int F_BUF_STAT         = 1;
  localparam int F_OL_TEMP          = 2;
  localparam int F_OL_STAT          = 3;
  localparam int F_RX_COIL          = 4;
  localparam int F_TX_COIL          = 5;
  localparam int F_TEMP             = 6;
  localparam int F_SUPPLY           = 7;
  localparam int F_GAIN             = 8;
  localparam int F_DIGITAL          = 9;
  localparam int F_SELF_TEST        = 10;
  localparam int F_ECC_SED          = 11;
  localparam int F_ECC_DED          = 12;
  localparam int F_FREQ             = 13;

  // ----------------------------------------------------------------
  // ecc geometry and frequency counter width
  // ----------------------------------------------------------------
  localparam int ECC_DATA_W         = 16;
  localparam int ECC_CHK_W          = 6;
  localparam int ECC_CODE_W         = 22;
  localparam int FREQ_W             = 16;

endpackage : dfm_pkg

// ### tb/dfm_host_model.sv
// Purpose: host side: interrupt sense and static latch clears
// Assumes: interrupt line pulled up outside, active low
// Notes:   a clear is one pulse launched on a rising edge
`timescale 1ns/1ps
module dfm_host_model (
  input  wire logic clk_sys,
  input  wire logic irq_line,
  output logic      irq_seen,
  output logic      clear_buf_static,
  output logic      clear_ol_static
);
  // released line reads high through the pull-up
  assign irq_seen = !irq_line;
  initial begin
    clear_buf_static = 1'b0;
    clear_ol_static  = 1'b0;
  end
  // single pulse: a held clear would hide a fault that comes straight back
  task automatic clear_static(input logic ol);
    @(posedge clk_sys);
    if (ol) clear_ol_static <= 1'b1;
    else clear_buf_static <= 1'b1;
    @(posedge clk_sys);
    clear_ol_static  <= 1'b0;
    clear_buf_static <= 1'b0;
  endtask : clear_static
endmodule : dfm_host_model

// ### tb/dfm_monitor_asserts.sv
// Purpose: port level checks of the diagnostic fault monitor
// Assumes: flag positions per dfm_pkg
// Notes:   bound into every dfm_monitor instance
`timescale 1ns/1ps
module dfm_monitor_asserts #(
  parameter int FREQ_W = dfm_pkg::FREQ_W
) (
  input wire logic                      clk_sys,
  input wire logic                      reset,
  input wire logic                      clk_en,
  input wire logic                      rx_coil_fault,
  input wire logic                      supply_fault,
  input wire logic [7:0]                gain_value,
  input wire logic [7:0]                gain_limit_low,
  input wire logic [7:0]                gain_limit_high,
  input wire logic [FREQ_W-1:0]         freq_limit_low,
  input wire logic [FREQ_W-1:0]         freq_limit_high,
  input wire logic [dfm_pkg::NFLAG-1:0] irq_enable,
  input wire logic                      clear_ol_static,
  input wire logic [dfm_pkg::NFLAG-1:0] diag_flags,
  input wire logic [FREQ_W-1:0]         freq_measure,
  input wire logic                      analog_out_enable,
  input wire logic                      addr_select_irq_pin_o,
  input wire logic                      addr_select_irq_pin_oe_n
);
  default clocking dfm_cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // helper
  // ----------------------------------------------------------------
  // last edge ran live; keeps $past off reset values
  logic live_reg;
  always_ff @(posedge clk_sys) begin
    live_reg <= !reset && clk_en;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_rx_coil_flag: assert property (
    live_reg |-> diag_flags[dfm_pkg::F_RX_COIL] == $past(rx_coil_fault))
    else $error("rx coil flag does not follow its cause");
  chk_gain_limit_flag: assert property (
    live_reg |-> diag_flags[dfm_pkg::F_GAIN] ==
      $past(gain_value <= gain_limit_low || gain_value >= gain_limit_high))
    else $error("gain flag wrong for the gain limits");
  chk_supply_latch: assert property (
    live_reg && $past(supply_fault || diag_flags[dfm_pkg::F_SUPPLY])
      |-> diag_flags[dfm_pkg::F_SUPPLY])
    else $error("supply flag not latched");
  chk_irq_pin_level: assert property (
    live_reg |-> !addr_select_irq_pin_o &&
      addr_select_irq_pin_oe_n == !(|$past(diag_flags & irq_enable)))
    else $error("interrupt pin does not match enabled flags");
  chk_ol_latch_off: assert property (
    diag_flags[dfm_pkg::F_OL_STAT] |-> !analog_out_enable)
    else $error("outputs on while overload latched");
  chk_buf_shutdown: assert property (
    $rose(diag_flags[dfm_pkg::F_BUF_TEMP]) |=> !analog_out_enable)
    else $error("outputs not off after buffer failure");
  chk_ol_host_clear: assert property (
    clk_en && clear_ol_static && diag_flags[dfm_pkg::F_OL_STAT]
      |=> !diag_flags[dfm_pkg::F_OL_STAT])
    else $error("overload latch not cleared by host");
  chk_freq_bounds: assert property (
    live_reg |-> diag_flags[dfm_pkg::F_FREQ] ==
      $past(freq_measure < freq_limit_low || freq_measure > freq_limit_high))
    else $error("frequency alarm wrong for the bounds");
endmodule : dfm_monitor_asserts

bind dfm_monitor dfm_monitor_asserts #(.FREQ_W(FREQ_W)) dfm_monitor_asserts_inst (.*);

// ### tb/tb_dfm_monitor.sv
// Purpose: directed bench for the diagnostic fault monitor
// Assumes: shortened debounce and check periods; clk_en held high
// Notes:   inputs move on rising edges, outputs read at falling edges
`timescale 1ns/1ps
module tb_dfm_monitor;
  localparam int OCA  = 4;
  localparam int OCD  = 8;
  localparam int BUFC = 8;

  logic                           clk_sys;
  logic                           reset = 1'b1;
  logic                           clk_en = 1'b1;
  logic                           startup_window = 1'b0;
  logic                           output_offset_alarm = 1'b0;
  logic                           output_overcurrent = 1'b0;
  logic [2:0]                     tmp_src = 3'h0;
  logic                           supply_fault = 1'b0;
  logic                           digital_fault = 1'b0;
  logic                           self_test_fail = 1'b0;
  logic [7:0]                     gain_value = 8'h80;
  logic [7:0]                     gain_limit_low = 8'h20;
  logic [7:0]                     gain_limit_high = 8'hC0;
  logic [dfm_pkg::ECC_CODE_W-1:0] ecc_word = '0;
  logic                           ecc_word_valid = 1'b0;
  logic                           tx_osc_tick = 1'b0;
  logic                           meas_gate = 1'b0;
  // low bound 0 until the frequency test: a zero measurement stays in range
  logic [dfm_pkg::FREQ_W-1:0]     freq_limit_low = 16'h0000;
  logic [dfm_pkg::FREQ_W-1:0]     freq_limit_high = 16'h000A;
  logic [dfm_pkg::NFLAG-1:0]      irq_enable = 16'hFFFF;
  logic                           diag_on_outputs = 1'b0;
  logic                           clear_buf_static;
  logic                           clear_ol_static;
  logic [dfm_pkg::NFLAG-1:0]      diag_flags;
  logic [dfm_pkg::FREQ_W-1:0]     freq_measure;
  logic [dfm_pkg::ECC_DATA_W-1:0] ecc_data;
  logic                           analog_out_enable;
  logic                           analog_diag_state;
  logic                           addr_select_irq_pin_o;
  logic                           addr_select_irq_pin_oe_n;
  logic                           irq_seen;
  wire                            irq_line;
  int                             tidx [3] = '{dfm_pkg::F_RX_COIL, dfm_pkg::F_TX_COIL,
                                               dfm_pkg::F_TEMP};
  logic [7:0]                     gval [4] = '{8'h20, 8'h21, 8'hBF, 8'hC0};
  int                             fcnt [4] = '{4, 5, 10, 11};
  logic [3:0]                     bexp = 4'h9;
  int                             comparisons = 0;
  int                             miscompares = 0;
  int                             falls = 0;

  // pull-up on the shared address/interrupt pin
  assign irq_line = addr_select_irq_pin_oe_n ? 1'b1 : addr_select_irq_pin_o;

  dfm_monitor #(
    .OC_ASSERT_CYC  (OCA),
    .OC_DEASSERT_CYC(OCD),
    .BUF_CHECK_CYC  (BUFC)
  ) dfm_monitor_inst (
    .rx_coil_fault(tmp_src[0]),
    .tx_coil_fault(tmp_src[1]),
    .temp_fault   (tmp_src[2]),
    .*
  );
  dfm_host_model dfm_host_model_inst (.*);

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge analog_out_enable) falls++;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic look(input int n);
    cyc(n);
    @(negedge clk_sys);
  endtask : look
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic flg(input int b, input logic e);
    chk($sformatf("diag_flags[%0d]", b), diag_flags[b], e);
  endtask : flg
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // whole run is near 460 cycles
  initial begin
    cyc(20000);
    miscompares++;
    results;
  end

  // ----------------------------------------------------------------
  // directed sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    reset <= 1'b0;
    look(1);
    chk("diag_flags", diag_flags, '0);
    chk("analog_out_enable", analog_out_enable, 1'b1);
    chk("analog_diag_state", analog_diag_state, 1'b0);
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      tmp_src[i] <= 1'b1;
      look(1);
      flg(tidx[i], 1'b1);
      look(1);
      chk("irq_seen", irq_seen, 1'b1);
      cyc(1);
      tmp_src[i] <= 1'b0;
      look(2);
      flg(tidx[i], 1'b0);
      chk("irq_seen", irq_seen, 1'b0);
    end
    cyc(1);
    irq_enable[dfm_pkg::F_GAIN] <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      gain_value <= gval[i];
      look(2);
      flg(dfm_pkg::F_GAIN, bexp[i]);
      chk("irq_seen", irq_seen, 1'b0);
    end
    cyc(1);
    self_test_fail <= 1'b1;
    look(2);
    flg(dfm_pkg::F_SELF_TEST, 1'b0);
    cyc(1);
    startup_window <= 1'b1;
    look(2);
    flg(dfm_pkg::F_SELF_TEST, 1'b1);
    cyc(1);
    startup_window <= 1'b0;
    self_test_fail <= 1'b0;
    supply_fault   <= 1'b1;
    digital_fault  <= 1'b1;
    cyc(1);
    supply_fault  <= 1'b0;
    digital_fault <= 1'b0;
    look(8);
    flg(dfm_pkg::F_SUPPLY, 1'b1);
    flg(dfm_pkg::F_DIGITAL, 1'b1);
    flg(dfm_pkg::F_SELF_TEST, 1'b1);
    cyc(1);
    diag_on_outputs <= 1'b1;
    look(1);
    chk("analog_diag_state", analog_diag_state, 1'b1);
    // all-zero word is a codeword in any layout, so flips need no encoder
    cyc(1);
    ecc_word_valid <= 1'b1;
    ecc_word       <= 22'h000008;
    look(2);
    flg(dfm_pkg::F_ECC_SED, 1'b1);
    flg(dfm_pkg::F_ECC_DED, 1'b0);
    chk("ecc_data", ecc_data, '0);
    cyc(1);
    ecc_word <= 22'h000028;
    look(2);
    flg(dfm_pkg::F_ECC_DED, 1'b1);
    cyc(1);
    ecc_word <= '0;
    look(2);
    flg(dfm_pkg::F_ECC_SED, 1'b0);
    flg(dfm_pkg::F_ECC_DED, 1'b1);
    cyc(1);
    freq_limit_low <= 16'h0005;
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      meas_gate   <= 1'b1;
      tx_osc_tick <= 1'b1;
      cyc(fcnt[i]);
      meas_gate   <= 1'b0;
      tx_osc_tick <= 1'b0;
      look(3);
      chk("freq_measure", freq_measure, fcnt[i]);
      flg(dfm_pkg::F_FREQ, bexp[i]);
    end
    // second pass shows the retry count restarted after the clear
    for (int r = 0; r < 2; r++) begin
      cyc(1);
      falls = 0;
      output_overcurrent <= 1'b1;
      look(2);
      flg(dfm_pkg::F_OL_TEMP, 1'b1);
      chk("shutdowns", falls, 0);
      for (int c = 0; c < 800 && diag_flags[dfm_pkg::F_OL_STAT] !== 1'b1; c++) cyc(1);
      look(20);
      flg(dfm_pkg::F_OL_STAT, 1'b1);
      chk("shutdowns", falls, dfm_pkg::RETRY_LIMIT);
      cyc(1);
      output_overcurrent <= 1'b0;
      look(4);
      chk("analog_out_enable", analog_out_enable, 1'b0);
      dfm_host_model_inst.clear_static(1'b1);
      look(2);
      flg(dfm_pkg::F_OL_STAT, 1'b0);
      chk("analog_out_enable", analog_out_enable, 1'b1);
    end
    cyc(1);
    output_offset_alarm <= 1'b1;
    look(1);
    flg(dfm_pkg::F_BUF_TEMP, 1'b1);
    look(1);
    chk("analog_out_enable", analog_out_enable, 1'b0);
    look(6 * BUFC);
    flg(dfm_pkg::F_BUF_STAT, 1'b0);
    for (int c = 0; c < 16 * BUFC && diag_flags[dfm_pkg::F_BUF_STAT] !== 1'b1; c++) cyc(1);
    cyc(1);
    output_offset_alarm <= 1'b0;
    look(4);
    flg(dfm_pkg::F_BUF_STAT, 1'b1);
    chk("analog_out_enable", analog_out_enable, 1'b0);
    dfm_host_model_inst.clear_static(1'b0);
    look(2);
    flg(dfm_pkg::F_BUF_STAT, 1'b0);
    chk("analog_out_enable", analog_out_enable, 1'b1);
    results;
  end
endmodule : tb_dfm_monitor
